//--- hw/aof_pkg.sv
/*
  Constants, types and helpers for the converter output, format and
  power control block. Assumes one 200 MHz clock and an APB port.
*/
// What this block does
// - Stabilizer samples on rise, makes own fall
// - Stabilizer takes 40-60% duty, keeps 50%
// - Stabilizer relocks after a hundred clock edges
// - Four-level pin picks format and stabilizer
// - Offset binary code, midscale 1000 0000 0000
// - Two's complement inverts the top bit
// - Out of range sets flag, clamps code
// - Tri-state control high floats all outputs
// - Power-down low means normal conversion
// - Power-down and tri-state high give sleep
// - Power-down high, tri-state low give nap
// - Sleep and nap float every output
// - No stabilizer: track on fall, hold on rise
package aof_pkg;
  // Timing in its own units
  localparam int unsigned CLK_PS       = 5000;     // 200 MHz period
  localparam int unsigned MAX_RATE_PS  = 12500;    // 80 Msps period
  localparam int unsigned MIN_RATE_PS  = 1000000;  // 1 Msps period
  localparam int unsigned HALF_MIN_PS  = 5900;     // Least half period
  localparam int unsigned SLEEP_REC_MS = 1;        // Wake time from sleep
  // Least times round up, longest round down
  localparam int unsigned PER_MIN_CYC  = (MAX_RATE_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HALF_MIN_CYC = (HALF_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned PER_MAX_CYC  = MIN_RATE_PS / CLK_PS;
  localparam int unsigned SLEEP_REC_DEF = SLEEP_REC_MS * 1000000000 / CLK_PS;
  localparam logic [6:0]  RELOCK_EDGES = 7'h64;    // Hundred edges
  localparam logic [6:0]  NAP_REC_EDGES = 7'h64;   // Hundred edges
  // Widths and depths
  localparam int CW     = 12;  // Sample code width
  localparam int CNT_W  = 8;   // Clock measure counters
  localparam int REC_W  = 18;  // Recovery counter
  localparam int AW     = 8;   // APB address
  localparam int DW     = 32;  // APB data
  localparam int PIPE_D = 5;   // Sample pipeline depth
  localparam int NIRQ   = 5;   // Interrupt sources
  localparam logic [CW-1:0] FS_POS = 12'hfff;  // Offset binary +FS
  localparam logic [CW-1:0] FS_NEG = 12'h000;  // Offset binary -FS
  // Register byte offsets
  localparam logic [AW-1:0] ADR_CTRL  = 8'h00;
  localparam logic [AW-1:0] ADR_STAT  = 8'h04;
  localparam logic [AW-1:0] ADR_ISTAT = 8'h08;
  localparam logic [AW-1:0] ADR_IMASK = 8'h0c;
  localparam logic [AW-1:0] ADR_LAST  = 8'h10;
  localparam logic [AW-1:0] ADR_CLKM  = 8'h14;
  localparam int CTRL_SEL_BIT  = 0;  // Use register mode, not pin
  localparam int CTRL_MODE_LSB = 1;  // Two-bit mode field
  // Interrupt bit positions
  localparam int IRQ_RANGE = 0;
  localparam int IRQ_FAST  = 1;
  localparam int IRQ_SLOW  = 2;
  localparam int IRQ_DUTY  = 3;
  localparam int IRQ_VALID = 4;
  // Pin levels in order: ground, 1/3, 2/3, full supply
  typedef enum logic [1:0] {MODE_OB_OFF, MODE_OB_ON, MODE_TC_ON, MODE_TC_OFF} aof_mode_e;
  typedef enum logic [1:0] {PWR_RUN, PWR_NAP, PWR_SLEEP} aof_pwr_e;
  typedef logic [CNT_W-1:0] aof_cnt_t;
  typedef struct packed {logic over; logic [CW-1:0] code;} aof_sample_s;
  typedef struct packed {
    aof_cnt_t per; aof_cnt_t hi;
    logic fast; logic slow; logic duty; logic locked; logic rise; logic fall;
  } aof_meas_s;
  typedef struct packed {
    logic prev; logic stopped; aof_cnt_t cnt; aof_cnt_t hcnt;
    aof_cnt_t per; aof_cnt_t hi; logic [6:0] lock;
  } aof_mon_s;
  typedef struct packed {
    logic rdy; logic slverr; logic [DW-1:0] prdata;
    logic cfg_sel; logic [1:0] cfg_mode;
    logic [NIRQ-1:0] istat; logic [NIRQ-1:0] imask; logic irq;
    logic track; aof_sample_s [PIPE_D-1:0] pipe; logic oe;
    aof_pwr_e pwr; logic rec_edge; logic [REC_W-1:0] rec; logic dvalid;
  } aof_top_s;
endpackage

//--- hw/aof_clk_mon.sv
/*
  Sample clock monitor: edges, period, duty, stabilizer lock.
  Assumes the sample clock level is synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module aof_clk_mon
  import aof_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      smp_clk,
  input  wire logic      dcs_on,
  output var  aof_meas_s meas
);
  aof_mon_s q;    // Registered state
  aof_mon_s n;    // Next state
  logic     rise; // Sample clock rising edge

  // Saturating increment keeps a stopped clock from wrapping
  function automatic aof_cnt_t sat_inc(input aof_cnt_t v);
    return (&v) ? v : v + 1'b1;
  endfunction

  // Duty window: 40-60% with stabilizer, else 45-55% and 2-cycle halves
  function automatic logic duty_bad(input aof_cnt_t hi, input aof_cnt_t per, input logic dcs);
    logic [CNT_W+4:0] h;
    logic [CNT_W+4:0] p;
    h = {5'h00, hi};
    p = {5'h00, per};
    if (dcs)
      return (h * 5 < p * 2) || (h * 5 > p * 3);
    return (h * 20 < p * 9) || (h * 20 > p * 11) || (hi < CNT_W'(HALF_MIN_CYC)) ||
           (per - hi < CNT_W'(HALF_MIN_CYC));
  endfunction

  assign rise = smp_clk & ~q.prev;

  // Next state and measurement outputs
  always_comb
  begin
    n = q;
    meas = '0;
    n.prev = smp_clk;
    n.cnt = sat_inc(q.cnt);
    n.hcnt = smp_clk ? sat_inc(q.hcnt) : q.hcnt;
    // A clock silent past the slowest rate counts as stopped
    // A rise landing on the limit itself is still a legal slowest period
    if (!q.stopped && q.cnt == CNT_W'(PER_MAX_CYC) && !rise)
    begin
      n.stopped = 1'b1;
      n.lock = '0;
      meas.slow = 1'b1;
    end
    if (rise)
    begin
      n.cnt = CNT_W'(1);
      n.hcnt = CNT_W'(1);
      n.stopped = 1'b0;
      if (!q.stopped)
      begin
        n.per = q.cnt;
        n.hi = q.hcnt;
        meas.fast = q.cnt < CNT_W'(PER_MIN_CYC);
        meas.duty = duty_bad(q.hcnt, q.cnt, dcs_on);
      end
      if (q.lock != RELOCK_EDGES)
        n.lock = q.lock + 1'b1;
    end
    meas.per = q.per;
    meas.hi = q.hi;
    meas.locked = q.lock == RELOCK_EDGES;
    meas.rise = rise;
    // Stabilizer makes its fall mid-period; otherwise the pin's own fall
    if (dcs_on)
      meas.fall = !q.stopped && q.per > CNT_W'(1) && q.cnt == {1'b0, q.per[CNT_W-1:1]};
    else
      meas.fall = ~smp_clk & q.prev;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '{prev: 1'b0, stopped: 1'b1, default: '0};
    else
      q <= n;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_unlock_a: assert property (
    meas.slow |=> !meas.locked [*2]) else $error("lock kept after clock stop");
  lock_count_a: assert property (
    $rose(meas.locked) |-> $past(q.lock) == RELOCK_EDGES - 7'h01 && $past(rise))
    else $error("lock reached without a hundred edges");
endmodule
`default_nettype wire

//--- hw/aof_top.sv
/*
  Output side of a 12-bit sampling converter: mode pin decode, code
  format, range clamp, pipeline, tri-state, sleep and nap, APB regs.
  Assumes all pins are synchronous to pclk and an APB master.
*/
`timescale 1ns/100ps
`default_nettype none
module aof_top
  import aof_pkg::*;
#(
  parameter int unsigned SLEEP_REC_CYC = SLEEP_REC_DEF  // Sleep wake, cycles
)
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [DW-1:0] pwdata,
  output logic      [DW-1:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          smp_clk,
  input  wire logic [1:0]    mode_level,
  input  wire logic          power_down_select,
  input  wire logic          out_hiz_req,
  input  wire logic [CW-1:0] core_code,
  input  wire logic          core_over,
  input  wire logic          core_under,
  output logic      [CW-1:0] sample_code_bits,
  output logic               range_exceeded_flag,
  output logic               sample_code_oe,
  output logic               range_flag_oe,
  output logic               track_o,
  output logic               data_valid,
  output logic               irq
);
  aof_top_s        q;       // Registered state
  aof_top_s        n;       // Next state
  aof_meas_s       m;       // Clock monitor results
  aof_mode_e       mode;    // Active mode
  logic            dcs;     // Stabilizer on
  logic            twos;    // Two's complement output
  logic            access;  // APB access phase
  logic            wr_ok;   // Write completes this edge
  logic [NIRQ-1:0] ev;      // Interrupt events this cycle
  logic [NIRQ-1:0] clr;     // W1C clear mask

  // Offset binary with range clamp, then top bit flip for two's complement
  function automatic aof_sample_s fmt_sample(
    input logic [CW-1:0] code,
    input logic          over,
    input logic          under,
    input logic          tc
  );
    aof_sample_s s;
    s.over = over | under;
    s.code = over ? FS_POS : (under ? FS_NEG : code);
    if (tc)
      s.code[CW-1] = ~s.code[CW-1];
    return s;
  endfunction

  // Address decode for the error response to reads and writes
  function automatic logic is_mapped(input logic [AW-1:0] a);
    return a == ADR_CTRL || a == ADR_STAT || a == ADR_ISTAT ||
           a == ADR_IMASK || a == ADR_LAST || a == ADR_CLKM;
  endfunction

  // Mode from pin or, when software asks, from the control register
  assign mode = q.cfg_sel ? aof_mode_e'(q.cfg_mode) : aof_mode_e'(mode_level);
  assign dcs = mode == MODE_OB_ON || mode == MODE_TC_ON;
  assign twos = mode == MODE_TC_ON || mode == MODE_TC_OFF;

  // Edge, period and lock tracking of the sample clock
  aof_clk_mon u_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .smp_clk (smp_clk),
    .dcs_on  (dcs),
    .meas    (m)
  );

  // A write lands only at the edge where pready is already high
  assign access = psel & penable;
  assign wr_ok = access & q.rdy & pwrite;
  assign clr = (wr_ok && paddr == ADR_ISTAT) ? pwdata[NIRQ-1:0] : '0;

  // Next state for everything
  always_comb
  begin
    n = q;
    ev = '0;

    // Power state from the two control pins
    if (q.pwr == PWR_RUN && q.rec != '0 && (!q.rec_edge || m.rise))
      n.rec = q.rec - 1'b1;
    if (power_down_select)
    begin
      // Reference off in sleep, kept on in nap
      n.pwr = out_hiz_req ? PWR_SLEEP : PWR_NAP;
    end
    else if (q.pwr == PWR_NAP)
    begin
      // Nap wake counts sample clock edges
      n.pwr = PWR_RUN;
      n.rec_edge = 1'b1;
      n.rec = REC_W'(NAP_REC_EDGES);
    end
    else if (q.pwr == PWR_SLEEP)
    begin
      // Sleep wake counts pclk cycles while the reference settles
      n.pwr = PWR_RUN;
      n.rec_edge = 1'b0;
      n.rec = REC_W'(SLEEP_REC_CYC);
    end

    // Sampling: track window opens on a fall, value held on the rise
    if (q.pwr == PWR_RUN && !power_down_select)
    begin
      if (m.fall)
        n.track = 1'b1;
      if (m.rise)
      begin
        // One new code per clock, fixed depth behind the hold edge
        n.track = 1'b0;
        n.pipe = {q.pipe[PIPE_D-2:0],
                  fmt_sample(core_code, core_over, core_under, twos)};
        ev[IRQ_RANGE] = n.pipe[PIPE_D-1].over;
      end
    end
    else
      n.track = 1'b0;

    // Outputs float on request and in every power-down state
    n.oe = (n.pwr == PWR_RUN) & ~out_hiz_req;
    // Valid once recovered and, with stabilizer, locked
    n.dvalid = n.pwr == PWR_RUN && n.rec == '0 && (!dcs || m.locked);

    // Clock monitor events
    ev[IRQ_FAST] = m.fast;
    ev[IRQ_SLOW] = m.slow;
    ev[IRQ_DUTY] = m.duty;
    ev[IRQ_VALID] = n.dvalid & ~q.dvalid;

    // APB: first access cycle latches the answer, second completes
    n.rdy = 1'b0;
    // Error pulses with pready so the pin comes straight from its flop
    n.slverr = 1'b0;
    if (access && !q.rdy)
    begin
      n.rdy = 1'b1;
      n.slverr = !is_mapped(paddr);
      n.prdata = '0;
      if (!pwrite)
      begin
        case (paddr)
          ADR_CTRL:  n.prdata = DW'({q.cfg_mode, q.cfg_sel});
          ADR_STAT:  n.prdata = DW'({q.track, q.dvalid, m.locked, q.pwr, mode});
          ADR_ISTAT: n.prdata = DW'(q.istat);
          ADR_IMASK: n.prdata = DW'(q.imask);
          ADR_LAST:  n.prdata = DW'(q.pipe[PIPE_D-1]);
          ADR_CLKM:  n.prdata = DW'({m.hi, m.per});
          default:   n.prdata = '0;
        endcase
      end
    end

    // Register writes; unmapped writes are dropped with an error
    if (wr_ok)
    begin
      case (paddr)
        ADR_CTRL:
        begin
          n.cfg_sel = pwdata[CTRL_SEL_BIT];
          n.cfg_mode = pwdata[CTRL_MODE_LSB +: 2];
        end
        ADR_IMASK: n.imask = pwdata[NIRQ-1:0];
        default:   n.imask = q.imask;
      endcase
    end

    // Sticky status: a new event beats a clear in the same cycle
    n.istat = (q.istat & ~clr) | ev;
    n.irq = |(n.istat & n.imask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '{pwr: PWR_RUN, rec_edge: 1'b1, rec: REC_W'(PIPE_D), default: '0};
    else
      q <= n;
  end

  // Every output straight from the state register
  assign prdata = q.prdata;
  assign pready = q.rdy;
  assign pslverr = q.slverr;
  assign sample_code_bits = q.pipe[PIPE_D-1].code;
  assign range_exceeded_flag = q.pipe[PIPE_D-1].over;
  assign sample_code_oe = q.oe;
  assign range_flag_oe = q.oe;
  assign track_o = q.track;
  assign data_valid = q.dvalid;
  assign irq = q.irq;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic run_smp;  // A sample is taken this cycle
  assign run_smp = m.rise && q.pwr == PWR_RUN && !power_down_select;

  pin_decode_a: assert property (
    !q.cfg_sel |-> twos == mode_level[1] && dcs == (mode_level[1] ^ mode_level[0]))
    else $error("mode pin decoded wrongly");
  ob_code_a: assert property (
    run_smp && !twos && !core_over && !core_under |=> q.pipe[0].code == $past(core_code))
    else $error("offset binary code altered");
  twos_code_a: assert property (
    run_smp && twos && !core_over && !core_under
    |=> q.pipe[0].code == {~$past(core_code[CW-1]), $past(core_code[CW-2:0])})
    else $error("two's complement code wrong");
  over_clamp_a: assert property (
    run_smp && core_over && !twos |=> q.pipe[0].over && q.pipe[0].code == FS_POS)
    else $error("over range not clamped");
  under_clamp_a: assert property (
    run_smp && core_under && !core_over && !twos |=> q.pipe[0].over && q.pipe[0].code == FS_NEG)
    else $error("under range not clamped");
  in_range_a: assert property (
    run_smp && !core_over && !core_under |=> !q.pipe[0].over)
    else $error("range flag set in range");
  hiz_req_a: assert property (
    out_hiz_req |=> !sample_code_oe && !range_flag_oe)
    else $error("outputs driven while tri-state requested");
  run_drive_a: assert property (
    !power_down_select && !out_hiz_req && q.pwr == PWR_RUN |=> sample_code_oe)
    else $error("outputs not driven in normal operation");
  sleep_entry_a: assert property (
    power_down_select && out_hiz_req |=> q.pwr == PWR_SLEEP)
    else $error("sleep not entered");
  nap_wake_a: assert property (
    q.pwr == PWR_NAP && !power_down_select
    |=> q.rec == REC_W'(NAP_REC_EDGES) && !data_valid)
    else $error("nap wake not counted");
  pd_float_a: assert property (
    power_down_select |=> !sample_code_oe && !range_flag_oe)
    else $error("output driven in power down");
  pipe_step_a: assert property (
    run_smp |=> q.pipe[PIPE_D-1] == $past(q.pipe[PIPE_D-2]))
    else $error("pipeline did not advance");
  pipe_hold_a: assert property (
    !m.rise |=> $stable(q.pipe))
    else $error("pipeline moved without a sample edge");
  track_open_a: assert property (
    m.fall && !m.rise && q.pwr == PWR_RUN && !power_down_select |=> track_o)
    else $error("track window not opened");
endmodule
`default_nettype wire

//--- test/aof_sample_src.sv
/*
  Far-side model: the sample clock source and the quantizer feed.
  Assumes pclk at 200 MHz; the sample clock runs out of reset unless clk_stop is high.
*/
`timescale 1ns/100ps
`default_nettype none
module aof_sample_src
  import aof_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [CW-1:0] want_code,
  input  wire logic          want_over,
  input  wire logic          want_under,
  input  wire logic          clk_stop,
  output logic               smp_clk,
  output logic      [1:0]    phase,
  output logic      [CW-1:0] core_code,
  output logic               core_over,
  output logic               core_under
);
  // Four pclk per sample: 50 Msps, both halves 10 ns, 50 % duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase      <= 2'h3;
      smp_clk    <= 1'b0;
      core_code  <= 12'h000;
      core_over  <= 1'b0;
      core_under <= 1'b0;
    end
    else if (clk_stop)
    begin
      // Stopped clock rests low and restarts with a rise
      phase   <= 2'h3;
      smp_clk <= 1'b0;
    end
    else
    begin
      phase      <= phase + 2'h1;
      smp_clk    <= (phase == 2'h3) || (phase == 2'h0);
      // Valid only in the rise cycle; inverted otherwise so a late capture shows
      core_code  <= (phase == 2'h3) ? want_code : ~want_code;
      core_over  <= (phase == 2'h3) ? want_over : ~want_over;
      core_under <= (phase == 2'h3) ? want_under : ~want_under;
    end
  end
endmodule
`default_nettype wire

//--- test/adc_output_format_power_control_test.sv
/*
  Self-checking bench for the converter output block: format, range,
  pipeline delay, tri-state, sleep, nap and the APB registers.
  Assumes the partner model gives one sample rise every four pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_output_format_power_control_test;
  import aof_pkg::*;
  localparam int unsigned SLP = 50;  // Short sleep recovery for simulation
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic          smp_clk, power_down_select, out_hiz_req, core_over, core_under;
  logic          want_over, want_under, range_exceeded_flag, sample_code_oe;
  logic          range_flag_oe, track_o, data_valid, irq, clk_stop;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd, rnd;
  logic [1:0]    mode_level, phase;
  logic [CW-1:0] core_code, want_code, sample_code_bits;
  logic [12:0]   last;     // Flag and code expected at the pins now
  int            mismatches, compares, seed, i;

  aof_top #(.SLEEP_REC_CYC(SLP)) dut
  (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .smp_clk, .mode_level, .power_down_select, .out_hiz_req, .core_code,
    .core_over, .core_under, .sample_code_bits, .range_exceeded_flag, .sample_code_oe,
    .range_flag_oe, .track_o, .data_valid, .irq
  );
  aof_sample_src src
  (
    .pclk, .presetn, .want_code, .want_over, .want_under, .smp_clk, .phase, .core_code,
    .core_over, .core_under, .clk_stop
  );

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Verdict and end of run
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; an idle cycle first keeps drives one per time step
  task automatic apb(input logic wr_en, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                     output logic [DW-1:0] rdat, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr_en;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    e    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] m,
                        input logic [DW-1:0] e);
    apb(1'b0, a, '0, rd, err);
    chk(nm, rd & m, e);
  endtask

  // Step to the cycle where the partner shows the given phase
  task automatic at_phase(input logic [1:0] p);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end while (phase !== p && n < 8);
    if (phase !== p)
    begin
      mismatches++;
      conclude();
    end
  endtask

  // Bounded wait for valid data; a miss ends the run
  task automatic wait_dv(input int lim);
    int n;
    n = 0;
    while (data_valid !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("data valid", data_valid, 1);
    if (data_valid !== 1'b1)
      conclude();
  endtask

  // Pin value for a sample: clamp first, then flip the top bit for two's complement
  function automatic logic [12:0] expect_out(input logic [CW-1:0] c, input logic ov,
                                             input logic un, input logic tc);
    logic [CW-1:0] v;
    v = ov ? FS_POS : (un ? FS_NEG : c);
    v[CW-1] = v[CW-1] ^ tc;
    return {ov | un, v};
  endfunction

  // Rise k lands one edge after rise k+4: old value 17 edges on, new at 18
  task automatic send(input logic [1:0] md, input logic [CW-1:0] c, input logic ov,
                      input logic un);
    logic [12:0] nxt;
    nxt = expect_out(c, ov, un, md[1]);
    at_phase(2'h2);
    @(posedge pclk);
    mode_level <= md;
    want_code  <= c;
    want_over  <= ov;
    want_under <= un;
    repeat (17) @(posedge pclk);
    #1;
    chk("held sample", {range_exceeded_flag, sample_code_bits}, last);
    @(posedge pclk);
    #1;
    chk("new sample", {range_exceeded_flag, sample_code_bits}, nxt);
    chk("driving", {sample_code_oe, range_flag_oe}, 2'b11);
    last = nxt;
  endtask

  initial
  begin
    seed = 32'h3e71e9a9;
    mismatches = 0;
    compares = 0;
    last = 13'h0000;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {power_down_select, out_hiz_req, mode_level} = '0;
    {want_over, want_under, want_code} = '0;
    clk_stop = 1'b0;
    @(posedge pclk);
    #1;
    chk("reset outputs", {sample_code_oe, range_flag_oe, irq, pready}, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    // Register reset values and an unmapped place
    rd_chk("ctrl reset", ADR_CTRL, 32'h7, 0);
    rd_chk("imask reset", ADR_IMASK, 32'h1f, 0);
    wr(8'h18, 32'hffffffff);
    chk("unmapped write", err, 1);
    rd_chk("unmapped read", 8'h18, 32'hffffffff, 0);
    chk("unmapped error", err, 1);
    wait_dv(200);
    // Every mode, midscale corners, then random codes with range events
    for (i = 0; i < 16; i++)
    begin
      rnd = $random(seed);
      send(i[1:0], (i < 4) ? 12'h800 : rnd[CW-1:0], (i % 5) == 4, (i % 7) == 5);
      rd_chk("active mode", ADR_STAT, 32'h3, {30'h0, i[1:0]});
    end
    // Range interrupt: status, mask, clear
    rd_chk("range status", ADR_ISTAT, 32'h1, 32'h1);
    chk("irq masked", irq, 0);
    wr(ADR_IMASK, 32'h1 << IRQ_RANGE);
    @(posedge pclk);
    #1;
    chk("irq raised", irq, 1);
    wr(ADR_ISTAT, 32'h1);
    rd_chk("range cleared", ADR_ISTAT, 32'h1, 0);
    @(posedge pclk);
    #1;
    chk("irq cleared", irq, 0);
    wr(ADR_IMASK, 32'h0);
    // Register mode overrides the pin, then hands back
    wr(ADR_CTRL, 32'h3);
    rd_chk("register mode", ADR_STAT, 32'h3, 32'h1);
    wr(ADR_CTRL, 32'h0);
    rd_chk("pin mode", ADR_STAT, 32'h3, 32'h3);
    // Tracking window without the stabilizer
    at_phase(2'h3);
    chk("track open", track_o, 1);
    at_phase(2'h1);
    chk("track shut", track_o, 0);
    // Tri-state only: outputs float while the power state stays run
    @(posedge pclk);
    out_hiz_req <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("hiz oe", {sample_code_oe, range_flag_oe}, 0);
    rd_chk("run state", ADR_STAT, 32'hc, 0);
    // Sleep and its long recovery
    @(posedge pclk);
    power_down_select <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("sleep valid", data_valid, 0);
    rd_chk("sleep state", ADR_STAT, 32'hc, 32'h8);
    @(posedge pclk);
    power_down_select <= 1'b0;
    out_hiz_req <= 1'b0;
    repeat (40) @(posedge pclk);
    #1;
    chk("sleep wake", data_valid, 0);
    wait_dv(40);
    // Nap floats outputs even with tri-state low
    @(posedge pclk);
    power_down_select <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("nap oe", {sample_code_oe, range_flag_oe}, 0);
    rd_chk("nap state", ADR_STAT, 32'hc, 32'h4);
    @(posedge pclk);
    power_down_select <= 1'b0;
    repeat (360) @(posedge pclk);
    #1;
    chk("nap wake", data_valid, 0);
    wait_dv(100);
    // Stopped clock with the stabilizer on: stop event, then a full relock
    @(posedge pclk);
    mode_level <= 2'h2;
    at_phase(2'h2);
    @(posedge pclk);
    clk_stop <= 1'b1;
    repeat (250) @(posedge pclk);
    #1;
    chk("stop valid", data_valid, 0);
    rd_chk("stop event", ADR_ISTAT, 32'h1 << IRQ_SLOW, 32'h1 << IRQ_SLOW);
    rd_chk("stop unlock", ADR_STAT, 32'h10, 0);
    @(posedge pclk);
    clk_stop <= 1'b0;
    repeat (300) @(posedge pclk);
    #1;
    chk("relock wait", data_valid, 0);
    wait_dv(200);
    send(2'h3, 12'h5a5, 1'b0, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
